// ### dual_timer_counter.sv
`timescale 1ns/10ps
`include "dual_timer_regs.svh"
module dual_timer_counter
(
	input wire logic clk,
	input wire logic sys_rst,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [11:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	input wire logic countPin0,
	input wire logic countPin1,
	input wire logic externalIrqPin0,
	input wire logic externalIrqPin1,
	input wire dual_timer_pkg::ack_t ack,
	output logic ovfIrq0,
	output logic ovfIrq1,
	output logic extIrq0,
	output logic extIrq1
);
	typedef struct packed
	{
		logic [7:0] control;
		logic [7:0] modeReg;
		logic [1:0] prescale;
		logic [7:0] status;
		dual_timer_pkg::count_t count0;
		dual_timer_pkg::count_t count1;
		dual_timer_pkg::count_t reload0;
		dual_timer_pkg::count_t reload1;
		logic [7:0] oscCount;
		logic [3:0] pinSync0;
		logic [3:0] pinSync1;
		logic [3:0] irqSync0;
		logic [3:0] irqSync1;
		logic [31:0] rdata;
	} state_t;

	state_t cur;
	state_t next_cur;

	// one bit of the four-bit synchroniser chains: [0] first flop, [1] second, [2] sampled, [3] previous sample
	logic sampleTick;
	logic baseTick;
	logic [7:0] divisor;
	logic wrAcc;
	logic rdAcc;
	logic cnt0Fall;
	logic cnt1Fall;
	logic irq0Fall;
	logic irq1Fall;
	logic en0;
	logic en1;
	logic inc0;
	logic inc1;
	logic incHigh0;
	logic ovf0;
	logic ovf1;
	logic [16:0] sum0;
	logic [16:0] sum1;
	logic [8:0] sumLow0;
	logic [8:0] sumHigh0;
	logic [8:0] sumLow1;
	logic [7:0] sel;
	dual_timer_pkg::tmode_t mode0;
	dual_timer_pkg::tmode_t mode1;

	// register select, one bit per mapped word, shared by the write and read paths
	function automatic logic [7:0] decode(input logic [11:0] addr);
		decode = 8'h00;
		if (addr == `ADDR_TIMER_CONTROL)
			decode[0] = 1'b1;
		else if (addr == `ADDR_TIMER_MODE)
			decode[1] = 1'b1;
		else if (addr == `ADDR_SYSTEM_CONFIG)
			decode[2] = 1'b1;
		else if (addr == `ADDR_COUNT_ZERO)
			decode[3] = 1'b1;
		else if (addr == `ADDR_COUNT_ONE)
			decode[4] = 1'b1;
		else if (addr == `ADDR_RELOAD_ZERO)
			decode[5] = 1'b1;
		else if (addr == `ADDR_RELOAD_ONE)
			decode[6] = 1'b1;
		else if (addr == `ADDR_TIMER_STATUS)
			decode[7] = 1'b1;
	endfunction

	// apb slave answers in the access cycle, no wait states
	// a write lands at the access edge; read data is captured at setup so it stands through access
	assign pready = 1'b1;
	assign pslverr = 1'b0;
	assign prdata = cur.rdata;
	assign wrAcc = psel && penable && pready && pwrite;
	assign rdAcc = psel && !penable && !pwrite;
	assign sel = decode(paddr);

	// decoded mode fields
	assign mode0 = dual_timer_pkg::tmode_t'(cur.modeReg[3:0]);
	assign mode1 = dual_timer_pkg::tmode_t'(cur.modeReg[7:4]);

	// prescaler divisor selection, reserved code behaves as osc/4
	always_comb
	begin
		case (cur.prescale)
			2'b01: divisor = `DIV_OSC16;
			2'b10: divisor = `DIV_OSC64;
			default: divisor = `DIV_OSC4;
		endcase
	end

	// base clock and pin sample ticks from oscillator cycle count
	// a divisor shortened mid-count restarts at once instead of waiting for the counter to wrap
	assign baseTick = (cur.oscCount >= divisor - 8'h01);
	assign sampleTick = cur.oscCount[0] == (`PIN_SAMPLE_CYCLES == 8'h02 ? 1'b1 : 1'b0);

	// falling edges: count pins from the sampled levels, irq pins from the synchronised levels every cycle
	assign cnt0Fall = sampleTick && cur.pinSync0[3] && !cur.pinSync0[2];
	assign cnt1Fall = sampleTick && cur.pinSync1[3] && !cur.pinSync1[2];
	assign irq0Fall = cur.irqSync0[3] && !cur.irqSync0[2];
	assign irq1Fall = cur.irqSync1[3] && !cur.irqSync1[2];

	// count enables: run bit, optionally gated by irq pin level
	function automatic logic enable(input logic run, input logic gate, input logic pinHigh);
		enable = run && (!gate || pinHigh);
	endfunction

	function automatic logic tick(input logic counter, input logic fall, input logic base);
		tick = counter ? fall : base;
	endfunction

	assign en0 = enable(cur.control[`TC_RUN0], mode0.gate, cur.irqSync0[2]);
	assign en1 = enable(cur.control[`TC_RUN1], mode1.gate, cur.irqSync1[2])
		&& (mode1.mode != dual_timer_pkg::MODE_SPLIT);
	assign inc0 = en0 && tick(mode0.counter, cnt0Fall, baseTick);
	assign inc1 = en1 && tick(mode1.counter, cnt1Fall, baseTick);
	// split high byte: internal clock, run bit one only
	assign incHigh0 = cur.control[`TC_RUN1] && baseTick;

	assign sum0 = {1'b0, cur.count0} + 17'h00001;
	assign sum1 = {1'b0, cur.count1} + 17'h00001;
	assign sumLow0 = {1'b0, cur.count0.low} + 9'h001;
	assign sumHigh0 = {1'b0, cur.count0.high} + 9'h001;
	assign sumLow1 = {1'b0, cur.count1.low} + 9'h001;

	////////////////////////////////////////////////////////////////////////////////
	// next state
	always_comb
	begin
		next_cur = cur;
		ovf0 = 1'b0;
		ovf1 = 1'b0;
		next_cur.oscCount = baseTick ? 8'h00 : cur.oscCount + 8'h01;
		// synchroniser chains: first flop only feeds second
		next_cur.pinSync0[1:0] = {cur.pinSync0[0], countPin0};
		next_cur.pinSync1[1:0] = {cur.pinSync1[0], countPin1};
		next_cur.irqSync0 = {cur.irqSync0[2], cur.irqSync0[1], cur.irqSync0[0], externalIrqPin0};
		next_cur.irqSync1 = {cur.irqSync1[2], cur.irqSync1[1], cur.irqSync1[0], externalIrqPin1};
		if (sampleTick)
		begin
			next_cur.pinSync0[3:2] = {cur.pinSync0[2], cur.pinSync0[1]};
			next_cur.pinSync1[3:2] = {cur.pinSync1[2], cur.pinSync1[1]};
		end

		// timer 0
		case (mode0.mode)
			dual_timer_pkg::MODE_RELOAD16:
				if (inc0)
				begin
					ovf0 = sum0[16];
					next_cur.count0 = sum0[16] ? cur.reload0 : sum0[15:0];
				end
			dual_timer_pkg::MODE_FREE16:
				if (inc0)
				begin
					ovf0 = sum0[16];
					next_cur.count0 = sum0[15:0];
				end
			dual_timer_pkg::MODE_RELOAD8:
				if (inc0)
				begin
					ovf0 = sumLow0[8];
					next_cur.count0.low = sumLow0[8] ? cur.reload0.low : sumLow0[7:0];
				end
			default:
			begin
				if (inc0)
				begin
					ovf0 = sumLow0[8];
					next_cur.count0.low = sumLow0[7:0];
				end
				if (incHigh0)
				begin
					ovf1 = sumHigh0[8];
					next_cur.count0.high = sumHigh0[7:0];
				end
			end
		endcase

		// timer 1, counts on in its own modes even while timer 0 is split
		if (inc1)
		begin
			case (mode1.mode)
				dual_timer_pkg::MODE_RELOAD16:
				begin
					next_cur.count1 = sum1[16] ? cur.reload1 : sum1[15:0];
					if (mode0.mode != dual_timer_pkg::MODE_SPLIT)
						ovf1 = sum1[16];
				end
				dual_timer_pkg::MODE_FREE16:
				begin
					next_cur.count1 = sum1[15:0];
					if (mode0.mode != dual_timer_pkg::MODE_SPLIT)
						ovf1 = sum1[16];
				end
				default:
				begin
					next_cur.count1.low = sumLow1[8] ? cur.reload1.low : sumLow1[7:0];
					if (mode0.mode != dual_timer_pkg::MODE_SPLIT)
						ovf1 = sumLow1[8];
				end
			endcase
		end

		// register writes land at the access edge
		// they follow the counter updates, so software wins over a count in the same cycle
		if (wrAcc)
		begin
			if (sel[0])
				next_cur.control = pwdata[7:0];
			else if (sel[1])
				next_cur.modeReg = pwdata[7:0];
			else if (sel[2])
				next_cur.prescale = pwdata[3:2];
			else if (sel[3])
				next_cur.count0 = pwdata[15:0];
			else if (sel[4])
				next_cur.count1 = pwdata[15:0];
			else if (sel[5])
				next_cur.reload0 = pwdata[15:0];
			else if (sel[6])
				next_cur.reload1 = pwdata[15:0];
			else if (sel[7])
				next_cur.status = pwdata[7:0] & 8'h05;
		end

		// hardware acknowledge clears
		if (ack.vector0)
			next_cur.control[`TC_OVF0] = 1'b0;
		if (ack.vector1)
			next_cur.control[`TC_OVF1] = 1'b0;
		if (ack.extAck0)
			next_cur.control[`TC_EXT0] = 1'b0;
		if (ack.extAck1)
			next_cur.control[`TC_EXT1] = 1'b0;

		// order: software write, then acknowledge clear, then hardware set
		// a toggle output enable holds the overflow flag off; the count itself runs on
		// hardware sets win over any clear in the same cycle
		if (ovf0 && !cur.status[`TS_TOG0])
			next_cur.control[`TC_OVF0] = 1'b1;
		if (ovf1 && !cur.status[`TS_TOG1])
			next_cur.control[`TC_OVF1] = 1'b1;
		if (cur.control[`TC_TYP0] ? irq0Fall : !cur.irqSync0[2])
			next_cur.control[`TC_EXT0] = 1'b1;
		if (cur.control[`TC_TYP1] ? irq1Fall : !cur.irqSync1[2])
			next_cur.control[`TC_EXT1] = 1'b1;

		// read data captured in setup phase, unmapped reads zero
		// the value is the one before this edge's update and stands through the access phase
		if (rdAcc)
		begin
			if (sel[0])
				next_cur.rdata = {24'h000000, cur.control};
			else if (sel[1])
				next_cur.rdata = {24'h000000, cur.modeReg};
			else if (sel[2])
				next_cur.rdata = {28'h0000000, cur.prescale, 2'b00};
			else if (sel[3])
				next_cur.rdata = {16'h0000, cur.count0};
			else if (sel[4])
				next_cur.rdata = {16'h0000, cur.count1};
			else if (sel[5])
				next_cur.rdata = {16'h0000, cur.reload0};
			else if (sel[6])
				next_cur.rdata = {16'h0000, cur.reload1};
			else if (sel[7])
				next_cur.rdata = {24'h000000, cur.status};
			else
				next_cur.rdata = 32'h00000000;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// state register
	// pins idle high, so the chains reset to ones and no false edge follows reset
	always_ff @(posedge clk or posedge sys_rst)
	begin
		if (sys_rst)
		begin
			cur <= '0;
			cur.pinSync0 <= 4'hF;
			cur.pinSync1 <= 4'hF;
			cur.irqSync0 <= 4'hF;
			cur.irqSync1 <= 4'hF;
		end
		else
			cur <= next_cur;
	end

	// interrupt request levels straight from the flags
	assign ovfIrq0 = cur.control[`TC_OVF0];
	assign ovfIrq1 = cur.control[`TC_OVF1];
	assign extIrq0 = cur.control[`TC_EXT0];
	assign extIrq1 = cur.control[`TC_EXT1];
endmodule // dual_timer_counter

// ### dual_timer_regs.svh
`ifndef DUAL_TIMER_REGS_SVH
`define DUAL_TIMER_REGS_SVH
// register byte addresses (apb word aligned)
`define ADDR_TIMER_CONTROL 12'h410
`define ADDR_TIMER_MODE 12'h45C
`define ADDR_SYSTEM_CONFIG 12'h440
`define ADDR_COUNT_ZERO 12'h600
`define ADDR_COUNT_ONE 12'h604
`define ADDR_RELOAD_ZERO 12'h608
`define ADDR_RELOAD_ONE 12'h60C
`define ADDR_TIMER_STATUS 12'h610
// timer_control field positions
`define TC_OVF1 7
`define TC_RUN1 6
`define TC_OVF0 5
`define TC_RUN0 4
`define TC_EXT1 3
`define TC_TYP1 2
`define TC_EXT0 1
`define TC_TYP0 0
// timer_mode field positions per timer nibble
`define TM_GATE 3
`define TM_CNT 2
// timer_status field positions
`define TS_TOG1 2
`define TS_TOG0 0
// reset values
`define RST_BYTE 8'h00
// prescaler divisors in oscillator cycles
`define DIV_OSC4 8'h04
`define DIV_OSC16 8'h10
`define DIV_OSC64 8'h40
// external count pin sample period in oscillator cycles
`define PIN_SAMPLE_CYCLES 8'h02
`endif

// ### dual_timer_pkg.sv
package dual_timer_pkg;
	typedef enum logic [1:0] {MODE_RELOAD16, MODE_FREE16, MODE_RELOAD8, MODE_SPLIT} mode_t;
	typedef struct packed
	{
		logic [7:0] high;
		logic [7:0] low;
	} count_t;
	typedef struct packed
	{
		logic gate;
		logic counter;
		mode_t mode;
	} tmode_t;
	typedef struct packed
	{
		logic vector1;
		logic vector0;
		logic extAck1;
		logic extAck0;
	} ack_t;
endpackage

// ### dual_timer_counter_props.sv
`timescale 1ns/10ps
`include "dual_timer_regs.svh"
module dual_timer_counter_props
(
	input wire logic clk,
	input wire logic sys_rst,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [11:0] paddr,
	input wire logic [31:0] pwdata,
	input wire logic [31:0] prdata,
	input wire logic pready,
	input wire logic pslverr,
	input wire logic countPin0,
	input wire logic countPin1,
	input wire logic externalIrqPin0,
	input wire logic externalIrqPin1,
	input wire dual_timer_pkg::ack_t ack,
	input wire logic ovfIrq0,
	input wire logic ovfIrq1,
	input wire logic extIrq0,
	input wire logic extIrq1
);
	logic wrCtl, wrSt, typ0, tog0, tog1;
	logic [2:0] lowAge;
	////////////////////////////////////////////////////////////////////////
	// write strobes at the access edge, where a write lands
	assign wrCtl = psel && penable && pwrite && paddr == `ADDR_TIMER_CONTROL;
	assign wrSt = psel && penable && pwrite && paddr == `ADDR_TIMER_STATUS;
	// shadows of software bits and age of the last low on irq pin 0
	always_ff @(posedge clk or posedge sys_rst)
	begin
		if (sys_rst)
		begin
			typ0 <= 1'b0;
			tog0 <= 1'b0;
			tog1 <= 1'b0;
			lowAge <= 3'h7;
		end
		else
		begin
			if (wrCtl)
				typ0 <= pwdata[0];
			if (wrSt)
			begin
				tog0 <= pwdata[0];
				tog1 <= pwdata[2];
			end
			lowAge <= !externalIrqPin0 ? 3'h0 : (lowAge == 3'h7 ? 3'h7 : lowAge + 3'h1);
		end
	end
	////////////////////////////////////////////////////////////////////////
	default clocking @(posedge clk); endclocking
	default disable iff (sys_rst);
	property p_ready; pready && !pslverr; endproperty
	a_ready: assert property (p_ready) else $error("bus answer not ready or error");
	property p_hold; $changed(prdata) |-> $past(psel && !penable && !pwrite); endproperty
	a_hold: assert property (p_hold) else $error("read data moved outside a read");
	property p_ctlwr; wrCtl |=> ovfIrq0 == $past(pwdata[5]) && ovfIrq1 == $past(pwdata[7]); endproperty
	a_ctlwr: assert property (p_ctlwr) else $error("flag write not taken");
	property p_ack0; ack.vector0 && !wrCtl |=> !ovfIrq0; endproperty
	a_ack0: assert property (p_ack0) else $error("vector ack did not clear flag");
	property p_tog0; $rose(ovfIrq0) |-> !$past(tog0) || $past(wrCtl); endproperty
	a_tog0: assert property (p_tog0) else $error("flag zero set while toggle on");
	property p_tog1; $rose(ovfIrq1) |-> !$past(tog1) || $past(wrCtl); endproperty
	a_tog1: assert property (p_tog1) else $error("flag one set while toggle on");
	property p_ext; $rose(extIrq0) |-> lowAge < 3'h6 || $past(wrCtl); endproperty
	a_ext: assert property (p_ext) else $error("edge flag without a low pin");
	property p_level; (!typ0 && !externalIrqPin0 && !wrCtl && !ack.extAck0) [*5] |=> extIrq0; endproperty
	a_level: assert property (p_level) else $error("low level did not raise flag");
endmodule // dual_timer_counter_props

// ### tb.sv
`timescale 1ns/10ps
`include "dual_timer_regs.svh"
module tb;
	logic clk = 1'b0;
	logic sys_rst, psel, penable, pwrite, pready, pslverr, countPin0, countPin1, externalIrqPin0, externalIrqPin1;
	logic ovfIrq0, ovfIrq1, extIrq0, extIrq1;
	logic [11:0] paddr;
	logic [31:0] pwdata, prdata, q;
	logic [7:0] lb, rh, hb;
	logic [15:0] diff;
	dual_timer_pkg::ack_t ack;
	int failures, comparisons, n, cyc, k, dummy;
	////////////////////////////////////////////////////////////////////////
	// clock generator
	always #2.5 clk = ~clk;
	dual_timer_counter dut (.clk(clk), .sys_rst(sys_rst), .psel(psel), .penable(penable), .pwrite(pwrite),
		.paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
		.countPin0(countPin0), .countPin1(countPin1), .externalIrqPin0(externalIrqPin0),
		.externalIrqPin1(externalIrqPin1), .ack(ack), .ovfIrq0(ovfIrq0), .ovfIrq1(ovfIrq1),
		.extIrq0(extIrq0), .extIrq1(extIrq1));
	////////////////////////////////////////////////////////////////////////
	// verdict and end of run
	task final_report;
		$display("failures=%0d comparisons=%0d", failures, comparisons);
		if (failures == 0 && comparisons > 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	endtask
	task check(input logic ok, input string msg);
		comparisons++;
		if (ok !== 1'b1)
		begin
			failures++;
			$display("MISMATCH %0t %s", $time, msg);
		end
	endtask
	// one apb transfer, held until pready
	task apb(input logic w, input logic [11:0] a, input logic [31:0] d, output logic [31:0] r);
		int i;
		@(posedge clk);
		psel <= 1'b1; penable <= 1'b0; pwrite <= w; paddr <= a; pwdata <= d;
		@(posedge clk);
		penable <= 1'b1;
		i = 0;
		do
		begin
			@(posedge clk);
			i++;
		end while (pready !== 1'b1 && i < 20);
		if (i >= 20)
		begin
			failures++;
			final_report();
		end
		r = prdata;
		psel <= 1'b0; penable <= 1'b0;
	endtask
	task wr(input logic [11:0] a, input logic [31:0] d);
		logic [31:0] r;
		apb(1'b1, a, d, r);
	endtask
	// wait for an overflow flag, bounded
	task waitFlag(input int t, output int c);
		c = 0;
		while ((t ? ovfIrq1 : ovfIrq0) !== 1'b1 && c < 5000) begin @(posedge clk); c++; end
		if (c >= 5000)
		begin
			failures++;
			final_report();
		end
	endtask
	// falling edges on count pin zero or one, four cycles low and five high between pulses
	task pulse(input int p, input int s);
		repeat (p)
		begin
			@(posedge clk);
			if (s)
				countPin1 <= 1'b0;
			else
				countPin0 <= 1'b0;
			repeat (4) @(posedge clk);
			if (s)
				countPin1 <= 1'b1;
			else
				countPin0 <= 1'b1;
			repeat (4) @(posedge clk);
		end
	endtask
	function automatic int expCycles(int m, logic [15:0] s, int d);
		return (m == 2 ? 256 - int'(s[7:0]) : 65536 - int'(s)) * d;
	endfunction
	function automatic logic [15:0] expCount(int m);
		return m == 0 ? {rh, lb} : (m == 1 ? 16'h0000 : {hb, lb});
	endfunction
	////////////////////////////////////////////////////////////////////////
	// main sequence
	initial
	begin
		sys_rst = 1'b1; psel = 1'b0; penable = 1'b0; pwrite = 1'b0; paddr = 12'h000; pwdata = 32'h0;
		countPin0 = 1'b1; countPin1 = 1'b1; externalIrqPin0 = 1'b1; externalIrqPin1 = 1'b1; ack = '0;
		dummy = $urandom(2);
		repeat (8) @(posedge clk);
		sys_rst <= 1'b0;
		apb(1'b0, `ADDR_TIMER_CONTROL, 32'h0, q);
		check(q === 32'h0, "control reset value");
		apb(1'b0, 12'h7F0, 32'h0, q);
		check(q === 32'h0, "unmapped read");
		for (int p = 0; p < 3; p++)
			for (int t = 0; t < 2; t++)
				for (int m = 0; m < 3; m++)
				begin
					n = 4 << (2 * p);
					lb = 8'hF0 + 8'($urandom % 8);
					rh = 8'($urandom);
					hb = (m == 2) ? 8'($urandom) : 8'hFF;
					wr(`ADDR_SYSTEM_CONFIG, 32'(p << 2));
					wr(`ADDR_TIMER_MODE, 32'(m << (4 * t)));
					wr(t ? `ADDR_RELOAD_ONE : `ADDR_RELOAD_ZERO, {16'h0, rh, lb});
					wr(t ? `ADDR_COUNT_ONE : `ADDR_COUNT_ZERO, {16'h0, hb, lb});
					wr(`ADDR_TIMER_CONTROL, t ? 32'h40 : 32'h10);
					waitFlag(t, cyc);
					k = expCycles(m, {hb, lb}, n);
					check(cyc > k - n - 6 && cyc < k + 6, "overflow time");
					wr(`ADDR_TIMER_CONTROL, 32'h0);
					@(posedge clk);
					check((t ? ovfIrq1 : ovfIrq0) === 1'b0, "flag not cleared");
					apb(1'b0, t ? `ADDR_COUNT_ONE : `ADDR_COUNT_ZERO, 32'h0, q);
					diff = q[15:0] - expCount(m);
					check(diff <= 16'h0002, "count after overflow");
				end
		wr(`ADDR_SYSTEM_CONFIG, 32'h0);
		wr(`ADDR_TIMER_MODE, 32'h33);
		wr(`ADDR_COUNT_ONE, 32'h1234);
		wr(`ADDR_COUNT_ZERO, 32'hF8F8);
		wr(`ADDR_TIMER_CONTROL, 32'h50);
		waitFlag(0, cyc);
		waitFlag(1, cyc);
		check(ovfIrq1 === 1'b1, "split high byte flag");
		apb(1'b0, `ADDR_COUNT_ONE, 32'h0, q);
		check(q[15:0] === 16'h1234, "timer one not held");
		@(posedge clk);
		ack.vector0 <= 1'b1; ack.vector1 <= 1'b1;
		@(posedge clk);
		ack <= '0;
		@(posedge clk);
		check(ovfIrq0 === 1'b0 && ovfIrq1 === 1'b0, "vector ack");
		wr(`ADDR_TIMER_MODE, 32'h13);
		repeat (40) @(posedge clk);
		apb(1'b0, `ADDR_COUNT_ONE, 32'h0, q);
		diff = q[15:0] - 16'h1234;
		check(diff >= 16'h0005 && diff <= 16'h000E, "timer one not resumed");
		wr(`ADDR_TIMER_CONTROL, 32'h0);
		wr(`ADDR_TIMER_STATUS, 32'h5);
		wr(`ADDR_TIMER_MODE, 32'h11);
		wr(`ADDR_COUNT_ZERO, 32'hFFF8);
		wr(`ADDR_COUNT_ONE, 32'hFFF8);
		wr(`ADDR_TIMER_CONTROL, 32'h50);
		repeat (60) @(posedge clk);
		check(ovfIrq0 === 1'b0 && ovfIrq1 === 1'b0, "flag set under toggle");
		wr(`ADDR_TIMER_STATUS, 32'h0);
		wr(`ADDR_TIMER_MODE, 32'h0D);
		wr(`ADDR_COUNT_ZERO, 32'h0);
		wr(`ADDR_TIMER_CONTROL, 32'h10);
		k = 3 + int'($urandom % 6);
		pulse(k, 0);
		apb(1'b0, `ADDR_COUNT_ZERO, 32'h0, q);
		check(q[15:0] === 16'(k), "pin edge count");
		@(posedge clk);
		externalIrqPin0 <= 1'b0;
		pulse(3, 0);
		apb(1'b0, `ADDR_COUNT_ZERO, 32'h0, q);
		check(q[15:0] === 16'(k), "gate closed but counted");
		check(extIrq0 === 1'b1, "low level flag");
		@(posedge clk);
		externalIrqPin0 <= 1'b1;
		wr(`ADDR_TIMER_CONTROL, 32'h05);
		@(posedge clk);
		externalIrqPin1 <= 1'b0;
		repeat (8) @(posedge clk);
		check(extIrq1 === 1'b1, "falling edge flag");
		ack.extAck1 <= 1'b1;
		@(posedge clk);
		ack <= '0;
		@(posedge clk);
		check(extIrq1 === 1'b0, "edge flag not processed");
		wr(`ADDR_TIMER_MODE, 32'h40);
		wr(`ADDR_COUNT_ONE, 32'h0);
		wr(`ADDR_TIMER_CONTROL, 32'h40);
		k = 2 + int'($urandom % 6);
		pulse(k, 1);
		apb(1'b0, `ADDR_COUNT_ONE, 32'h0, q);
		check(q[15:0] === 16'(k), "pin one edge count");
		final_report();
	end
endmodule // tb
bind dual_timer_counter dual_timer_counter_props props (.clk(clk), .sys_rst(sys_rst), .psel(psel),
	.penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
	.pslverr(pslverr), .countPin0(countPin0), .countPin1(countPin1), .externalIrqPin0(externalIrqPin0),
	.externalIrqPin1(externalIrqPin1), .ack(ack), .ovfIrq0(ovfIrq0), .ovfIrq1(ovfIrq1),
	.extIrq0(extIrq0), .extIrq1(extIrq1));
